// *** verilog/flyback_ctrl_regs.vh ***
// Constants for the flyback burst and current-limit control block
`ifndef FLYBACK_CTRL_REGS_VH
`define FLYBACK_CTRL_REGS_VH

// Register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_PERIOD      4'h8
`define REG_BLANK       4'hc

// Control fields
`define CTRL_RUN_BIT    0
`define CTRL_HIFREQ_BIT 1

// Status fields
`define ST_BURST_BIT    0
`define ST_SWITCH_BIT   1
`define ST_OPT_LO       2
`define ST_ISO_BIT      4
`define ST_FAULT_LO     5
`define ST_GATE_BIT     8

// Reset values
`define CTRL_RESET      32'h0000_0001
`define PERIOD_RESET    16'h00fa

// Timing: clock, times in ns
`define CLK_NS          40
`define BLANK_NS        280
`define BEB_NS          36000
`define SS_NS           12000000
`define SS_STEP_NS      3000000
`define ARST_NS         1000000

// Burst frequencies in kHz
`define ABM_LO_KHZ      83
`define ABM_HI_KHZ      103

// Duty split for the compensation curve and maximum duty, percent
`define DUTY_SPLIT_PCT  40
`define DUTY_MAX_PCT    75

// Burst options
`define OPT_NONE        2'h1
`define OPT_LOW         2'h2
`define OPT_HIGH        2'h3

// Restart styles
`define RST_NONE        3'h0
`define RST_NOSWITCH    3'h1
`define RST_ODDSKIP     3'h2
`define RST_PLAIN       3'h3
`define RST_NOSTART     3'h4

`endif

// *** verilog/flyback_burst_limit_control.v ***
// Burst mode, current limit and protection control for a flyback switcher
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "flyback_ctrl_regs.vh"

// Behaviour
// - Current over limit ends pulse at once
// - Ignore current sense during turn-on blanking
// - Pick limit curve by on-time versus 0.40
// - Reduced delay compensation while bursting
// - Enter burst after full entry blanking time
// - Burst stops switching until burst-on level
// - Burst-off level stops switching until burst-on
// - Burst frequency 83 or 103 kHz
// - Burst current limit 0.22 or 0.27 V
// - Leave level exits burst, normal limit
// - Three options: none, 0.93 V, 1.03 V
// - Option decoded from two bias thresholds
// - Startup presets option 3, selection source
// - Latch option at turn-on, reconnect resistor
// - Error pin over 0.2 V means non-isolated
// - Isolated keeps error amplifier disconnected
// - Non-isolated drives feedback from error amp
// - Faults map to their restart styles
// - Protections monitored per operating state
// - Auto restart resumes with soft start
module flyback_burst_limit_control
#(
   parameter SS_CYCLES   = `SS_NS / `CLK_NS,
   parameter ARST_CYCLES = `ARST_NS / `CLK_NS,
   parameter BEB_CYCLES  = (`BEB_NS + `CLK_NS - 1) / `CLK_NS
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Comparators from the analog front end
   input  wire        csOverNormLo,
   input  wire        csOverNormHi,
   input  wire        csOverNormLoBurst,
   input  wire        csOverNormHiBurst,
   input  wire        csOverBurstLow,
   input  wire        csOverBurstHigh,
   input  wire        csOverSoftStart,
   input  wire        fbBelowEntryLow,
   input  wire        fbBelowEntryHigh,
   input  wire        fbAboveBurstOn,
   input  wire        fbBelowBurstOff,
   input  wire        fbAboveLeave,
   input  wire        fbAboveBiasFirst,
   input  wire        fbAboveBiasSecond,
   input  wire        errAboveBias,
   input  wire        vccAboveStart,
   input  wire        vccAboveOn,
   input  wire        vccBelowOff,
   input  wire        vccShort,
   input  wire        vccOver,
   input  wire        lineOver,
   input  wire        overTemp,
   input  wire        overLoad,
   // Analog switches and gate
   output reg         selCurrentOn,
   output reg         fbResistorOn,
   output reg         errAmpConnect,
   output reg         burstLimitSel,
   output reg         gateOn
);

   localparam NIN = 23;

   localparam [2:0] S_OFF    = 3'h0;
   localparam [2:0] S_SEL    = 3'h1;
   localparam [2:0] S_NORM   = 3'h2;
   localparam [2:0] S_BOFF   = 3'h3;
   localparam [2:0] S_BON    = 3'h4;
   localparam [2:0] S_FAULT  = 3'h5;

   localparam integer CLK_KHZ    = 1000000 / `CLK_NS;
   localparam integer BLANK_INT  = (`BLANK_NS + `CLK_NS - 1) / `CLK_NS;
   localparam integer ABM_LO_INT = CLK_KHZ / `ABM_LO_KHZ;
   localparam integer ABM_HI_INT = CLK_KHZ / `ABM_HI_KHZ;
   localparam [15:0]  BLANK_CYC  = BLANK_INT[15:0];
   localparam [15:0]  ABM_LO_PER = ABM_LO_INT[15:0];
   localparam [15:0]  ABM_HI_PER = ABM_HI_INT[15:0];
   localparam [31:0]  CTRL_RST   = `CTRL_RESET;

   // ==========================================================
   // Input synchronisers
   wire [NIN-1:0] rawIn = {csOverNormLo, csOverNormHi, csOverNormLoBurst, csOverNormHiBurst,
      csOverBurstLow, csOverBurstHigh, csOverSoftStart, fbBelowEntryLow, fbBelowEntryHigh,
      fbAboveBurstOn, fbBelowBurstOff, fbAboveLeave, fbAboveBiasFirst, fbAboveBiasSecond,
      errAboveBias, vccAboveStart, vccAboveOn, vccBelowOff, vccShort, vccOver, lineOver,
      overTemp, overLoad};
   reg  [NIN-1:0] meta_q;
   reg  [NIN-1:0] sync_q;
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1)
      begin : g_sync
         always @(posedge clk)
         begin
            if (sys_rst)
            begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= rawIn[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire sNormLo   = sync_q[22];
   wire sNormHi   = sync_q[21];
   wire sNormLoB  = sync_q[20];
   wire sNormHiB  = sync_q[19];
   wire sBurstLo  = sync_q[18];
   wire sBurstHi  = sync_q[17];
   wire sSoft     = sync_q[16];
   wire sEntLo    = sync_q[15];
   wire sEntHi    = sync_q[14];
   wire sBOn      = sync_q[13];
   wire sBOff     = sync_q[12];
   wire sLeave    = sync_q[11];
   wire sBias1    = sync_q[10];
   wire sBias2    = sync_q[9];
   wire sErr      = sync_q[8];
   wire sVccStart = sync_q[7];
   wire sVccOn    = sync_q[6];
   wire sVccOff   = sync_q[5];
   wire sShort    = sync_q[4];
   wire sVccOv    = sync_q[3];
   wire sLine     = sync_q[2];
   wire sTemp     = sync_q[1];
   wire sOvl      = sync_q[0];

   // ==========================================================
   // Register file
   reg [1:0]  ctrl_q;
   reg [15:0] period_q;
   reg [15:0] blank_q;
   reg [2:0]  state_q;
   reg [1:0]  option_q;
   reg        isolated_q;
   reg [2:0]  fault_q;
   reg        rdAck_q;

   // One wait state per read, so read data stand while waitrequest is low
   assign waitrequest = read & ~rdAck_q;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_q   <= CTRL_RST[1:0];
         period_q <= `PERIOD_RESET;
         blank_q  <= BLANK_CYC;
      end
      else if (write)
      begin
         case (address)
            `REG_CTRL:   ctrl_q <= writedata[1:0];
            `REG_PERIOD: period_q <= writedata[15:0];
            `REG_BLANK:  blank_q <= (writedata[15:0] == 16'h0) ? 16'h1 : writedata[15:0];
            default:     ctrl_q <= ctrl_q;
         endcase
      end
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         readdata <= 32'h0;
         rdAck_q  <= 1'b0;
      end
      else
      begin
         rdAck_q <= read & ~rdAck_q;
         if (read & ~rdAck_q)
         begin
            case (address)
               `REG_CTRL:   readdata <= {30'h0, ctrl_q};
               `REG_STATUS: readdata <= {23'h0, gateOn, fault_q, isolated_q, option_q,
                                         (state_q == S_BON), (state_q == S_BOFF) |
                                         (state_q == S_BON)};
               `REG_PERIOD: readdata <= {16'h0, period_q};
               `REG_BLANK:  readdata <= {16'h0, blank_q};
               default:     readdata <= 32'h0;
            endcase
         end
      end
   end

   wire run    = ctrl_q[`CTRL_RUN_BIT];
   wire hiFreq = ctrl_q[`CTRL_HIFREQ_BIT];

   // ==========================================================
   // Protection monitoring
   wire inNorm  = (state_q == S_NORM);
   wire inBOn   = (state_q == S_BON);
   wire inBurst = inBOn | (state_q == S_BOFF);
   wire active  = inNorm | inBurst;
   wire fLine   = active & sLine;
   wire fTemp   = active & sTemp;
   wire fUv     = active & sVccOff;
   wire fShort  = sShort;
   wire fVccOv  = (inNorm | inBOn) & sVccOv;
   wire fOvl    = inNorm & sOvl;

   reg [2:0] faultKind;
   always @*
   begin
      faultKind = `RST_NONE;
      if (fShort)
         faultKind = `RST_NOSTART;
      else if (fUv)
         faultKind = `RST_PLAIN;
      else if (fLine | fTemp)
         faultKind = `RST_NOSWITCH;
      else if (fVccOv | fOvl)
         faultKind = `RST_ODDSKIP;
   end

   // ==========================================================
   // Mode state machine
   reg [31:0] tmr_q;
   reg [31:0] ss_q;
   reg        skip_q;
   wire entryBelow = (option_q == `OPT_LOW) ? sEntLo : sEntHi;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q       <= S_OFF;
         option_q      <= `OPT_HIGH;
         isolated_q    <= 1'b1;
         selCurrentOn  <= 1'b0;
         fbResistorOn  <= 1'b1;
         errAmpConnect <= 1'b0;
         fault_q       <= `RST_NONE;
         tmr_q         <= 32'h0;
         ss_q          <= 32'h0;
         skip_q        <= 1'b0;
      end
      else
      begin
         case (state_q)
            S_OFF:
               if (sVccStart & ~sShort)
               begin
                  state_q      <= S_SEL;
                  option_q     <= `OPT_HIGH;
                  fbResistorOn <= 1'b0;
                  selCurrentOn <= 1'b1;
               end
            S_SEL:
               if (sVccOn)
               begin
                  if (~sBias1)
                     option_q <= `OPT_NONE;
                  else if (~sBias2)
                     option_q <= `OPT_LOW;
                  else
                     option_q <= `OPT_HIGH;
                  isolated_q    <= ~sErr;
                  errAmpConnect <= sErr;
                  selCurrentOn  <= 1'b0;
                  fbResistorOn  <= 1'b1;
                  state_q       <= S_NORM;
                  ss_q          <= 32'h0;
                  tmr_q         <= 32'h0;
               end
            S_NORM, S_BOFF, S_BON:
            begin
               if (ss_q < SS_CYCLES)
                  ss_q <= ss_q + 32'h1;
               if (faultKind != `RST_NONE)
               begin
                  fault_q <= faultKind;
                  state_q <= S_FAULT;
                  tmr_q   <= 32'h0;
                  skip_q  <= 1'b0;
               end
               else if (inBurst & sLeave)
                  state_q <= S_NORM;
               else if (inNorm)
               begin
                  if ((option_q != `OPT_NONE) & entryBelow & ss_q >= SS_CYCLES)
                  begin
                     if (tmr_q >= BEB_CYCLES - 1)
                     begin
                        state_q <= S_BOFF;
                        tmr_q   <= 32'h0;
                     end
                     else
                        tmr_q <= tmr_q + 32'h1;
                  end
                  else
                     tmr_q <= 32'h0;
               end
               else if ((state_q == S_BOFF) & sBOn)
                  state_q <= S_BON;
               else if (inBOn & sBOff)
                  state_q <= S_BOFF;
            end
            S_FAULT:
            begin
               tmr_q <= tmr_q + 32'h1;
               if (fault_q == `RST_NOSTART)
               begin
                  if (~sShort)
                     state_q <= S_OFF;
               end
               else if (fault_q == `RST_PLAIN)
               begin
                  if (~sVccOff)
                     state_q <= S_OFF;
               end
               else if (tmr_q >= ARST_CYCLES - 1 & ~sLine & ~sTemp)
               begin
                  // Odd-skip style lets only every second restart attempt pass
                  tmr_q  <= 32'h0;
                  skip_q <= ~skip_q;
                  if ((fault_q != `RST_ODDSKIP) | skip_q)
                  begin
                     state_q <= S_NORM;
                     ss_q    <= 32'h0;
                  end
               end
            end
            default:
               state_q <= S_OFF;
         endcase
      end
   end

   // ==========================================================
   // PWM and peak current limit
   reg [15:0] cyc_q;
   wire [15:0] perLen = inBurst ? (hiFreq ? ABM_HI_PER : ABM_LO_PER) : period_q;
   wire [31:0] onLong = {16'h0, cyc_q} * 32'd100;
   wire [31:0] splitT = {16'h0, perLen} * `DUTY_SPLIT_PCT;
   wire [31:0] maxT   = {16'h0, perLen} * `DUTY_MAX_PCT;
   wire highDuty = onLong > splitT;
   wire normLimit = inBurst ? (highDuty ? sNormHiB : sNormLoB)
                            : (highDuty ? sNormHi : sNormLo);
   wire burstLim = (option_q == `OPT_LOW) ? sBurstLo : sBurstHi;
   wire ssLimit  = (ss_q < SS_CYCLES) & sSoft;
   wire overLim  = (inBurst ? (burstLim | normLimit) : normLimit) | ssLimit;
   wire blanked  = cyc_q < blank_q;
   wire mayRun   = run & (inNorm | inBOn);

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         cyc_q         <= 16'h0;
         gateOn        <= 1'b0;
         burstLimitSel <= 1'b0;
      end
      else
      begin
         burstLimitSel <= inBurst;
         if (cyc_q >= perLen - 16'h1)
         begin
            cyc_q  <= 16'h0;
            gateOn <= mayRun;
         end
         else
         begin
            cyc_q <= cyc_q + 16'h1;
            if (~mayRun | onLong >= maxT)
               gateOn <= 1'b0;
            else if (~blanked & overLim)
               gateOn <= 1'b0;
         end
      end
   end

endmodule // flyback_burst_limit_control

// *** dv/flyback_burst_limit_control_chk.sv ***
// Assertion checker for the flyback burst and current-limit block
`timescale 1ns/1ps
module flyback_burst_limit_control_chk
#(
   parameter BEB_CYCLES = 10
)
(
   // Clock, reset and bus
   input wire        clk,
   input wire        sys_rst,
   input wire [3:0]  address,
   input wire        read,
   input wire [31:0] readdata,
   // Comparators
   input wire        csOverNormLo,
   input wire        fbBelowEntryHigh,
   input wire        fbBelowBurstOff,
   input wire        fbAboveBurstOn,
   input wire        fbAboveLeave,
   input wire        vccShort,
   input wire        lineOver,
   input wire        overTemp,
   // Outputs
   input wire        selCurrentOn,
   input wire        fbResistorOn,
   input wire        burstLimitSel,
   input wire        gateOn
);
   reg [4:0] csCnt_q;
   reg [9:0] entryCnt_q;
   reg [9:0] offCnt_q;
   // ========
   // Saturating run-length counters
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         csCnt_q    <= 5'h00;
         entryCnt_q <= 10'h000;
         offCnt_q   <= 10'h000;
      end
      else
      begin
         csCnt_q    <= (gateOn && csOverNormLo) ? csCnt_q + {4'h0, ~&csCnt_q} : 5'h00;
         entryCnt_q <= fbBelowEntryHigh ? entryCnt_q + {9'h000, ~&entryCnt_q} : 10'h000;
         offCnt_q   <= (burstLimitSel && fbBelowBurstOff && !fbAboveBurstOn) ?
                       offCnt_q + {9'h000, ~&offCnt_q} : 10'h000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ========
   // Properties
   chk_select_swap: assert property (selCurrentOn |-> !fbResistorOn)
      else $error("selection source with resistor");
   chk_blank_min: assert property ($rose(gateOn) |=> gateOn [*4])
      else $error("pulse shorter than blanking");
   chk_limit_end: assert property (csCnt_q < 5'd15)
      else $error("gate kept on over limit");
   chk_entry_blank: assert property ($rose(burstLimitSel) |-> entryCnt_q >= BEB_CYCLES)
      else $error("burst entered too early");
   chk_leave_exit: assert property (fbAboveLeave [*6] |-> !burstLimitSel)
      else $error("burst not left");
   chk_burst_idle: assert property (offCnt_q >= 10'd400 |-> !gateOn)
      else $error("switching in burst off");
   chk_fault_stop: assert property ((lineOver || overTemp || vccShort) [*6] |-> !gateOn)
      else $error("gate on during fault");
   chk_unmapped_zero: assert property (read && address[1:0] != 2'h0 |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   cover property ($rose(burstLimitSel));
   cover property ($fell(gateOn) && csOverNormLo);
   cover property (offCnt_q == 10'd400);
endmodule // flyback_burst_limit_control_chk

bind flyback_burst_limit_control flyback_burst_limit_control_chk #(.BEB_CYCLES(BEB_CYCLES)) chk
(
   .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .readdata(readdata),
   .csOverNormLo(csOverNormLo), .fbBelowEntryHigh(fbBelowEntryHigh),
   .fbBelowBurstOff(fbBelowBurstOff), .fbAboveBurstOn(fbAboveBurstOn),
   .fbAboveLeave(fbAboveLeave), .vccShort(vccShort), .lineOver(lineOver),
   .overTemp(overTemp), .selCurrentOn(selCurrentOn), .fbResistorOn(fbResistorOn),
   .burstLimitSel(burstLimitSel), .gateOn(gateOn)
);

// *** dv/analog_front_model.sv ***
// Comparator model of the analog front end
`timescale 1ns/1ps
module analog_front_model
#(
   parameter BURST_ON  = 1250,
   parameter BURST_OFF = 1000,
   parameter BIAS1     = 500,
   parameter BIAS2     = 1500
)
(
   // Clock and gate
   input  wire        clk,
   input  wire        gateOn,
   // Levels in millivolts
   input  wire [11:0] fbMv,
   input  wire [11:0] csLimMv,
   // Comparator results
   output wire        csOver,
   output wire [6:0]  fbCmp
);
   reg [11:0] csMv_q;
   // Primary current ramps while the switch conducts
   always @(posedge clk)
   begin
      csMv_q <= !gateOn ? 12'h000 : (csMv_q > 12'hf00) ? csMv_q : csMv_q + 12'h014;
   end
   assign csOver = csMv_q > csLimMv;
   assign fbCmp  = {fbMv > 12'd2730, fbMv > BIAS2, fbMv > BIAS1, fbMv < BURST_OFF,
                    fbMv > BURST_ON, fbMv < 12'd1030, fbMv < 12'd930};
endmodule // analog_front_model

// *** dv/flyback_burst_limit_control_tb_top.sv ***
// Self-checking testbench for the flyback burst and current-limit block
`timescale 1ns/1ps
module flyback_burst_limit_control_tb_top;
   reg         clk;
   reg         sys_rst;
   reg  [3:0]  address;
   reg         read;
   reg         write;
   reg  [31:0] writedata;
   wire [31:0] readdata;
   wire        waitrequest;
   reg  [11:0] fbMv;
   reg  [11:0] csLimMv;
   reg         errAboveBias;
   reg         vccAboveStart;
   reg         vccAboveOn;
   reg  [5:0]  faults;
   wire        csOver;
   wire [6:0]  fbCmp;
   wire        selCurrentOn;
   wire        fbResistorOn;
   wire        errAmpConnect;
   wire        burstLimitSel;
   wire        gateOn;
   integer     err_count;
   integer     total_checks;
   integer     i;
   integer     n;
   reg  [31:0] q;
   reg  [31:0] d;
   flyback_burst_limit_control #(.SS_CYCLES(50), .ARST_CYCLES(20), .BEB_CYCLES(10)) dut
   (
      .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .csOverNormLo(csOver), .csOverNormHi(csOver), .csOverNormLoBurst(csOver),
      .csOverNormHiBurst(csOver), .csOverBurstLow(csOver), .csOverBurstHigh(csOver),
      .csOverSoftStart(csOver), .fbBelowEntryLow(fbCmp[0]), .fbBelowEntryHigh(fbCmp[1]),
      .fbAboveBurstOn(fbCmp[2]), .fbBelowBurstOff(fbCmp[3]), .fbAboveBiasFirst(fbCmp[4]),
      .fbAboveBiasSecond(fbCmp[5]), .fbAboveLeave(fbCmp[6]), .errAboveBias(errAboveBias),
      .vccAboveStart(vccAboveStart), .vccAboveOn(vccAboveOn), .vccBelowOff(faults[4]),
      .vccShort(faults[5]), .vccOver(faults[2]), .lineOver(faults[0]), .overTemp(faults[1]),
      .overLoad(faults[3]), .selCurrentOn(selCurrentOn), .fbResistorOn(fbResistorOn),
      .errAmpConnect(errAmpConnect), .burstLimitSel(burstLimitSel), .gateOn(gateOn)
   );
   analog_front_model model
   (
      .clk(clk), .gateOn(gateOn), .fbMv(fbMv), .csLimMv(csLimMv), .csOver(csOver),
      .fbCmp(fbCmp)
   );
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ========
   // Verdict, comparison and bus tasks
   task complete_run;
   begin
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task time_out;
   begin
      err_count = err_count + 1;
      $display("ERROR %0t wait ran out", $time);
      complete_run;
   end
   endtask
   initial
   begin
      #4000000;
      time_out;
   end
   task check(input [31:0] seen, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task bus(input w, input [3:0] a, input [31:0] wd, output [31:0] rd);
      integer k;
   begin
      @(posedge clk);
      address   <= a;
      writedata <= wd;
      write     <= w;
      read      <= !w;
      k = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0 && k < 100)
      begin
         @(posedge clk);
         k = k + 1;
      end
      if (k >= 100)
         time_out;
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   end
   endtask
   // Burst period in 25 MHz cycles for the 83 or 103 kHz burst rate
   function [31:0] burst_period(input hi);
   begin
      burst_period = 25000 / (hi ? 103 : 83);
   end
   endfunction
   // Restart style per fault: line, temp, vcc over, overload, vcc under, short
   function [2:0] restart_style(input integer f);
   begin
      restart_style = (f < 2) ? 3'h1 : (f < 4) ? 3'h2 : (f == 4) ? 3'h3 : 3'h4;
   end
   endfunction
   task wait_gate(output integer c);
   begin
      c = 0;
      while (gateOn !== 1'b0 && c < 2000)
      begin
         @(posedge clk);
         c = c + 1;
      end
      while (gateOn !== 1'b1 && c < 2000)
      begin
         @(posedge clk);
         c = c + 1;
      end
      if (c >= 2000)
         time_out;
   end
   endtask
   // Reset, then supply start with option and configuration selection
   task start_up(input [11:0] fb, input err);
   begin
      @(posedge clk);
      sys_rst       <= 1'b1;
      vccAboveStart <= 1'b0;
      vccAboveOn    <= 1'b0;
      faults        <= 6'h00;
      fbMv          <= fb;
      errAboveBias  <= err;
      repeat (20) @(posedge clk);
      sys_rst       <= 1'b0;
      vccAboveStart <= 1'b1;
      repeat (8) @(posedge clk);
      check(selCurrentOn, 1'b1);
      check(fbResistorOn, 1'b0);
      vccAboveOn <= 1'b1;
      repeat (8) @(posedge clk);
      check({selCurrentOn, fbResistorOn}, 2'h1);
      check(errAmpConnect, err);
      fbMv    <= 12'd2000;
      csLimMv <= 12'd200;
      repeat (80) @(posedge clk);
   end
   endtask
   // ========
   // Main sequence
   initial
   begin
      {sys_rst, read, write, errAboveBias, vccAboveStart, vccAboveOn} = 6'h20;
      {address, writedata, faults, err_count, total_checks} = 0;
      fbMv    = 12'd2000;
      csLimMv = 12'hfff;
      d = $urandom(34);
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, 4'h0, 0, q);
      check(q, 32'h1);
      bus(1'b0, 4'h8, 0, q);
      check(q, 32'hfa);
      bus(1'b0, 4'hc, 0, q);
      check(q, 32'h7);
      bus(1'b1, 4'hc, 0, q);
      bus(1'b0, 4'hc, 0, q);
      check(q, 32'h1);
      bus(1'b1, 4'h6, 32'h5, q);
      bus(1'b0, 4'h6, 0, q);
      check(q, 32'h0);
      d = 200 + $urandom % 100;
      bus(1'b1, 4'h8, d, q);
      bus(1'b0, 4'h8, 0, q);
      check(q, d);
      for (i = 1; i <= 3; i = i + 1)
      begin
         d = (i == 1) ? $urandom % 400 : (i == 2) ? 600 + $urandom % 800 : 1600 + $urandom % 1000;
         start_up(d[11:0], d[0]);
         bus(1'b0, 4'h4, 0, q);
         check(q[4:2], {~d[0], i[1:0]});
         fbMv <= 12'd300;
         repeat (40) @(posedge clk);
         bus(1'b0, 4'h4, 0, q);
         check(q[0], i != 1);
         if (i != 1)
         begin
            check(burstLimitSel, 1'b1);
            repeat (450) @(posedge clk);
            check(gateOn, 1'b0);
            faults <= 6'h08;
            repeat (8) @(posedge clk);
            bus(1'b0, 4'h4, 0, q);
            check(q[7:5], 3'h0);
            faults <= 6'h00;
            if (i == 2)
               bus(1'b1, 4'h0, 32'h3, q);
            fbMv <= 12'd1500;
            repeat (3) wait_gate(n);
            d = burst_period(i == 2);
            check(n >= d - 2 && n <= d + 2, 1'b1);
            fbMv <= 12'd900;
            repeat (8) @(posedge clk);
            bus(1'b0, 4'h4, 0, q);
            check(q[1:0], 2'h1);
            fbMv <= 12'd3000;
            repeat (8) @(posedge clk);
            check(burstLimitSel, 1'b0);
         end
      end
      for (i = 0; i < 6; i = i + 1)
      begin
         start_up(12'd2000, 1'b0);
         wait_gate(n);
         repeat (6) @(posedge clk);
         faults <= 6'h01 << i;
         repeat (8) @(posedge clk);
         bus(1'b0, 4'h4, 0, q);
         check(q[7:5], restart_style(i));
      end
      complete_run;
   end
endmodule // flyback_burst_limit_control_tb_top
